// file: verilog/acl_defs.vh
// Constants for the converter calibration and link format control block.
// Assumes a 125 MHz core clock and a 32-bit AXI4-Lite register bus.
`ifndef ACL_DEFS_VH
`define ACL_DEFS_VH

// Register byte offsets
`define ACL_REG_CTRL 8'h00
`define ACL_REG_LINK 8'h04
`define ACL_REG_DRV 8'h08
`define ACL_REG_STATUS 8'h0c

// Control register fields
`define ACL_CTRL_PD 0
`define ACL_CTRL_DIV_LO 1
`define ACL_CTRL_DIV_HI 2
`define ACL_CTRL_OFFBIN 3
`define ACL_CTRL_SCR 4
`define ACL_CTRL_SYSGATE 5
`define ACL_CTRL_RST 32'h0000_0000

// Link register fields: frames per multiframe minus one, test select, ramp step
`define ACL_LINK_KM1_LO 0
`define ACL_LINK_KM1_HI 4
`define ACL_LINK_TST_LO 8
`define ACL_LINK_TST_HI 11
`define ACL_LINK_STEP_LO 16
`define ACL_LINK_STEP_HI 31
`define ACL_LINK_RST 32'h0001_001f
`define ACL_KM1_MIN 5'h08

// Driver register fields
`define ACL_DRV_SWING_LO 0
`define ACL_DRV_SWING_HI 2
`define ACL_DRV_DEEMPH_LO 4
`define ACL_DRV_DEEMPH_HI 6
`define ACL_DRV_RST 32'h0000_0000

// Link status register fields
`define ACL_STAT_CAL_DONE 0
`define ACL_STAT_CAL_BUSY 1
`define ACL_STAT_PD 2
`define ACL_STAT_SUBCLASS_LO 4
`define ACL_STAT_SUBCLASS_HI 5

// Test sequence codes
`define ACL_TST_DATA 4'h0
`define ACL_TST_D215 4'h1
`define ACL_TST_K285 4'h2
`define ACL_TST_ILA 4'h3
`define ACL_TST_PRBS7 4'h4
`define ACL_TST_PRBS15 4'h5
`define ACL_TST_PRBS23 4'h6
`define ACL_TST_RAMP 4'h7

// Link octet constants
`define ACL_OCT_D215 8'hb5
`define ACL_OCT_K285 8'hbc
`define ACL_SUBCLASS 2'h1

// Timing, in sampling clock cycles
`define ACL_PWRUP_CYC 24'h80_2c80
`define ACL_CAL_CYC 24'h0f_4240

`endif

// file: verilog/acl_top.v
// Calibration sequencer, sample format, test sequences and link settings
// for a single-lane converter back end, with an AXI4-Lite register slave.
// Assumes the core clock is the device clock, and the framer, scrambler and
// 8b/10b encoder sit downstream of the lane word outputs.
// Contract
// - Auto calibration after 8.4M-cycle power-up delay
// - Calibration run lasts about one million cycles
// - Power-down then normal starts calibration, flag set
// - Two's complement default, offset binary selectable
// - Format applied before framing, scrambling, encoding
// - Link is subclass 1 only
// - Accept periodic, pulsed or one-shot SYSREF
// - Deterministic latency with standard SYSREF, subclass 1
// - One lane, settable K, optional scrambling
// - D21.5, K28.5, ILA, PRBS, ramp sequences
// - No idle, transport, RPAT or JSPAT patterns
// - No lane polarity inversion, AC coupling only
// - Swing and de-emphasis codes 0..7
// - Divide setting change re-initializes the link
// - Divide device clock by 1, 2, 4 or 8
`include "acl_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module acl_top #(
  parameter [23:0] P_PWRUP_CYC = `ACL_PWRUP_CYC,
  parameter [23:0] P_CAL_CYC = `ACL_CAL_CYC
) (
  input wire i_core_clk,
  input wire i_srst,
  input wire i_supply_ok,
  input wire i_clk_ok,
  input wire [13:0] i_sample,
  input wire i_sysref,
  input wire i_axi_awvalid,
  output reg o_axi_awready,
  input wire [7:0] i_axi_awaddr,
  input wire i_axi_wvalid,
  output reg o_axi_wready,
  input wire [31:0] i_axi_wdata,
  input wire [3:0] i_axi_wstrb,
  output reg o_axi_bvalid,
  input wire i_axi_bready,
  output reg [1:0] o_axi_bresp,
  input wire i_axi_arvalid,
  output reg o_axi_arready,
  input wire [7:0] i_axi_araddr,
  output reg o_axi_rvalid,
  input wire i_axi_rready,
  output reg [31:0] o_axi_rdata,
  output reg [1:0] o_axi_rresp,
  output reg o_sample_tick,
  output reg o_cal_active,
  output reg [15:0] o_lane_word,
  output reg [1:0] o_lane_is_k,
  output reg o_lane_valid,
  output reg o_ila_repeat,
  output reg o_link_reinit,
  output reg o_lmfc_align,
  output reg o_scramble_en,
  output reg [4:0] o_k_minus1,
  output reg [2:0] o_swing_code,
  output reg [2:0] o_deemph_code
);

  localparam [1:0] S_OFF = 2'h0;
  localparam [1:0] S_WAIT = 2'h1;
  localparam [1:0] S_CAL = 2'h2;
  localparam [1:0] S_DONE = 2'h3;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // Sixteen LFSR steps per sample; returns {word, next state}
  function [38:0] prbs16;
    input [22:0] st;
    input [3:0] mode;
    integer n;
    reg [22:0] s;
    reg [15:0] w;
    reg fb;
    begin
      s = st;
      w = 16'h0000;
      for (n = 0; n < 16; n = n + 1) begin
        if (mode == `ACL_TST_PRBS7) fb = s[6] ^ s[5];
        else if (mode == `ACL_TST_PRBS15) fb = s[14] ^ s[13];
        else fb = s[22] ^ s[17];
        w = {w[14:0], fb};
        s = {s[21:0], fb};
      end
      prbs16 = {w, s};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file and AXI4-Lite slave

  reg [31:0] ctrl_q;
  reg [31:0] link_q;
  reg [31:0] drv_q;
  reg [1:0] state_q;
  reg aw_held_q;
  reg w_held_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire aw_take = i_axi_awvalid && o_axi_awready;
  wire w_take = i_axi_wvalid && o_axi_wready;
  wire aw_ok = aw_held_q || aw_take;
  wire w_ok = w_held_q || w_take;
  wire [7:0] wa = aw_held_q ? awaddr_q : i_axi_awaddr;
  wire [31:0] wd = w_held_q ? wdata_q : i_axi_wdata;
  wire [3:0] ws = w_held_q ? wstrb_q : i_axi_wstrb;
  wire do_wr = aw_ok && w_ok && !o_axi_bvalid;
  // Subclass field is fixed and read only
  wire [31:0] status_w = {26'h0, `ACL_SUBCLASS, 1'b0, ctrl_q[`ACL_CTRL_PD],
                          (state_q == S_CAL), (state_q == S_DONE)};
  reg [31:0] link_d;

  always @* begin
    link_d = merge(link_q, wd, ws);
    // Frames per multiframe held at or above its floor
    if (link_d[`ACL_LINK_KM1_HI:`ACL_LINK_KM1_LO] < `ACL_KM1_MIN) begin
      link_d[`ACL_LINK_KM1_HI:`ACL_LINK_KM1_LO] = `ACL_KM1_MIN;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      ctrl_q <= `ACL_CTRL_RST;
      link_q <= `ACL_LINK_RST;
      drv_q <= `ACL_DRV_RST;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      o_axi_awready <= 1'b0;
      o_axi_wready <= 1'b0;
      o_axi_bvalid <= 1'b0;
      o_axi_bresp <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q <= i_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= i_axi_wdata;
        wstrb_q <= i_axi_wstrb;
      end
      o_axi_awready <= !aw_ok && !o_axi_awready && !o_axi_bvalid;
      o_axi_wready <= !w_ok && !o_axi_wready && !o_axi_bvalid;
      if (do_wr) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        o_axi_bvalid <= 1'b1;
        o_axi_bresp <= 2'h0;
        if (wa == `ACL_REG_CTRL) begin
          ctrl_q <= merge(ctrl_q, wd, ws) & 32'h0000_003f;
        end else if (wa == `ACL_REG_LINK) begin
          link_q <= link_d & 32'hffff_0f1f;
        end else if (wa == `ACL_REG_DRV) begin
          drv_q <= merge(drv_q, wd, ws) & 32'h0000_0077;
        end else if (wa == `ACL_REG_STATUS) begin
          o_axi_bresp <= 2'h0;
        end else begin
          o_axi_bresp <= 2'h2;
        end
      end else if (o_axi_bvalid && i_axi_bready) begin
        o_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_axi_arready <= 1'b0;
      o_axi_rvalid <= 1'b0;
      o_axi_rdata <= 32'h0000_0000;
      o_axi_rresp <= 2'h0;
    end else begin
      o_axi_arready <= !o_axi_arready && !o_axi_rvalid && i_axi_arvalid;
      if (i_axi_arvalid && o_axi_arready) begin
        o_axi_rvalid <= 1'b1;
        o_axi_rresp <= 2'h0;
        if (i_axi_araddr == `ACL_REG_CTRL) begin
          o_axi_rdata <= ctrl_q;
        end else if (i_axi_araddr == `ACL_REG_LINK) begin
          o_axi_rdata <= link_q;
        end else if (i_axi_araddr == `ACL_REG_DRV) begin
          o_axi_rdata <= drv_q;
        end else if (i_axi_araddr == `ACL_REG_STATUS) begin
          o_axi_rdata <= status_w;
        end else begin
          o_axi_rdata <= 32'h0000_0000;
          o_axi_rresp <= 2'h2;
        end
      end else if (o_axi_rvalid && i_axi_rready) begin
        o_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampling clock divider and link re-initialization

  wire pd = ctrl_q[`ACL_CTRL_PD];
  wire [1:0] div_code = ctrl_q[`ACL_CTRL_DIV_HI:`ACL_CTRL_DIV_LO];
  reg [2:0] div_cnt_q;
  reg [1:0] div_prev_q;
  // Ratio minus one: 0, 1, 3 or 7
  wire [2:0] div_last = (3'h1 << div_code) - 3'h1;
  wire tick = (div_cnt_q >= div_last);

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      div_cnt_q <= 3'h0;
      div_prev_q <= 2'h0;
      o_sample_tick <= 1'b0;
      o_link_reinit <= 1'b0;
    end else begin
      div_cnt_q <= tick ? 3'h0 : div_cnt_q + 3'h1;
      o_sample_tick <= tick;
      div_prev_q <= div_code;
      // Counter runs on; the >= compare absorbs a shrinking ratio
      o_link_reinit <= (div_prev_q != div_code);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer, counted in sampling clock cycles

  reg [23:0] cal_cnt_q;
  reg pd_prev_q;

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      state_q <= S_OFF;
      cal_cnt_q <= 24'h00_0000;
      pd_prev_q <= 1'b0;
      o_cal_active <= 1'b0;
    end else begin
      pd_prev_q <= pd;
      case (state_q)
        S_OFF: begin
          cal_cnt_q <= 24'h00_0000;
          if (i_supply_ok && i_clk_ok && !pd) begin
            // Leaving power-down is a manual recal: no power-up delay
            state_q <= pd_prev_q ? S_CAL : S_WAIT;
          end
        end
        S_WAIT: begin
          if (tick) cal_cnt_q <= cal_cnt_q + 24'h00_0001;
          if (pd || !i_supply_ok || !i_clk_ok) begin
            state_q <= S_OFF;
          end else if (tick && cal_cnt_q == P_PWRUP_CYC - 24'h00_0001) begin
            state_q <= S_CAL;
            cal_cnt_q <= 24'h00_0000;
          end
        end
        S_CAL: begin
          if (tick) cal_cnt_q <= cal_cnt_q + 24'h00_0001;
          if (pd) begin
            state_q <= S_OFF;
          end else if (tick && cal_cnt_q == P_CAL_CYC - 24'h00_0001) begin
            state_q <= S_DONE;
          end
        end
        default: begin
          if (pd) state_q <= S_OFF;
        end
      endcase
      o_cal_active <= (state_q == S_CAL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample format and test sequence selection, ahead of the framer

  wire [3:0] tst = link_q[`ACL_LINK_TST_HI:`ACL_LINK_TST_LO];
  wire is_prbs = (tst == `ACL_TST_PRBS7) || (tst == `ACL_TST_PRBS15) ||
                 (tst == `ACL_TST_PRBS23);
  reg [22:0] lfsr_q;
  wire [38:0] prbs_nx = prbs16(lfsr_q, tst);
  wire [13:0] fmt = {i_sample[13] ^ ctrl_q[`ACL_CTRL_OFFBIN], i_sample[12:0]};
  reg [15:0] ramp_q;
  reg sys_prev_q;

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      lfsr_q <= 23'h7f_ffff;
      ramp_q <= 16'h0000;
      o_lane_word <= 16'h0000;
      o_lane_is_k <= 2'h0;
      o_lane_valid <= 1'b0;
      o_ila_repeat <= 1'b0;
    end else begin
      o_lane_valid <= tick && !pd && (state_q == S_DONE);
      o_ila_repeat <= (tst == `ACL_TST_ILA);
      o_lane_is_k <= 2'h0;
      if (tick && is_prbs) lfsr_q <= prbs_nx[22:0];
      if (tick && tst == `ACL_TST_RAMP) begin
        ramp_q <= ramp_q + link_q[`ACL_LINK_STEP_HI:`ACL_LINK_STEP_LO];
      end
      if (tst == `ACL_TST_D215) begin
        o_lane_word <= {`ACL_OCT_D215, `ACL_OCT_D215};
      end else if (tst == `ACL_TST_K285) begin
        o_lane_word <= {`ACL_OCT_K285, `ACL_OCT_K285};
        o_lane_is_k <= 2'h3;
      end else if (is_prbs) begin
        o_lane_word <= prbs_nx[38:23];
      end else if (tst == `ACL_TST_RAMP) begin
        o_lane_word <= ramp_q;
      end else begin
        // Unsupported codes fall back to sample data
        o_lane_word <= {fmt, 2'b00};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SYSREF capture and link settings

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      sys_prev_q <= 1'b0;
      o_lmfc_align <= 1'b0;
      o_scramble_en <= 1'b0;
      o_k_minus1 <= 5'h1f;
      o_swing_code <= 3'h0;
      o_deemph_code <= 3'h0;
    end else begin
      sys_prev_q <= i_sysref;
      // Every gated rising edge realigns, whatever the SYSREF style
      o_lmfc_align <= ctrl_q[`ACL_CTRL_SYSGATE] && i_sysref && !sys_prev_q;
      o_scramble_en <= ctrl_q[`ACL_CTRL_SCR];
      o_k_minus1 <= link_q[`ACL_LINK_KM1_HI:`ACL_LINK_KM1_LO];
      o_swing_code <= drv_q[`ACL_DRV_SWING_HI:`ACL_DRV_SWING_LO];
      // No polarity control exists on the lane
      o_deemph_code <= drv_q[`ACL_DRV_DEEMPH_HI:`ACL_DRV_DEEMPH_LO];
    end
  end

endmodule // acl_top

`default_nettype wire

// file: tb/acl_rx_model.sv
// Link receiver stand-in: counts lane words and keeps the last one.
// Assumes one AC-coupled lane; a word is taken on the lane valid pulse.
`timescale 1ns/1ns
`default_nettype none
module acl_rx_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [15:0] i_word,
  input wire logic i_valid,
  output logic [31:0] o_n_words,
  output logic [15:0] o_last
);
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_n_words <= 32'h0;
    end else if (i_valid) begin
      // Single lane, taken as sent: no polarity flip
      o_n_words <= o_n_words + 32'h1;
      o_last <= i_word;
    end
  end
endmodule // acl_rx_model
`default_nettype wire

// file: tb/acl_top_props.sv
// Checker for acl_top, bound to its ports.
// Assumes a single core clock domain with synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module acl_top_props #(
  parameter [23:0] P_PWRUP_CYC = 24'h14,
  parameter [23:0] P_CAL_CYC = 24'h0a
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_axi_awvalid,
  input wire logic o_axi_awready,
  input wire logic o_axi_bvalid,
  input wire logic i_axi_bready,
  input wire logic i_axi_arvalid,
  input wire logic o_axi_arready,
  input wire logic o_axi_rvalid,
  input wire logic i_axi_rready,
  input wire logic [31:0] o_axi_rdata,
  input wire logic o_sample_tick,
  input wire logic o_cal_active,
  input wire logic o_lane_valid,
  input wire logic o_link_reinit,
  input wire logic o_lmfc_align,
  input wire logic [4:0] o_k_minus1
);
  logic [23:0] cal_n_q;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // Cycles spent calibrating; divide by eight stretches a run eightfold
  always @(posedge i_core_clk) begin
    if (i_srst || !o_cal_active) begin
      cal_n_q <= 24'h0;
    end else begin
      cal_n_q <= cal_n_q + 24'h1;
    end
  end
  sequence s_aw_take;
    i_axi_awvalid && o_axi_awready;
  endsequence
  sequence s_wr_answer;
    ##[1:4] o_axi_bvalid;
  endsequence
  rst_vals_a: assert property (
    disable iff (1'b0) i_srst |=> o_k_minus1 == 5'h1f && !o_lane_valid && !o_axi_bvalid)
    else $error("reset values not applied");
  wr_answer_a: assert property (s_aw_take |-> s_wr_answer)
    else $error("write response missing");
  bvalid_hold_a: assert property (o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid)
    else $error("write response dropped");
  rvalid_hold_a: assert property (
    o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata))
    else $error("read data dropped");
  rd_answer_a: assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid)
    else $error("read data late");
  ar_pulse_a: assert property (o_axi_arready |=> !o_axi_arready)
    else $error("arready held");
  lane_tick_a: assert property (o_lane_valid |-> o_sample_tick)
    else $error("lane word off tick");
  cal_len_a: assert property (
    $fell(o_cal_active) |-> cal_n_q >= P_CAL_CYC - 24'h1)
    else $error("calibration too short");
  cal_cap_a: assert property (cal_n_q <= 8 * P_CAL_CYC + 24'h4)
    else $error("calibration too long");
  reinit_pulse_a: assert property (o_link_reinit |=> !o_link_reinit)
    else $error("reinit not a pulse");
  align_pulse_a: assert property (o_lmfc_align |=> !o_lmfc_align)
    else $error("align not a pulse");
endmodule // acl_top_props
bind acl_top acl_top_props #(.P_PWRUP_CYC(P_PWRUP_CYC), .P_CAL_CYC(P_CAL_CYC)) u_props (.*);
`default_nettype wire

// file: tb/adc_calibration_and_link_format_tb.sv
// Bench for acl_top: AXI4-Lite master, random samples, lane receiver.
// Assumes shortened counts: 20 tick power-up wait, 10 tick calibration.
`timescale 1ns/1ns
`default_nettype none
module adc_calibration_and_link_format_tb;
  localparam int PW = 20;
  logic i_core_clk = 0, i_srst = 1, i_supply_ok = 0, i_clk_ok = 0, i_sysref = 0;
  logic i_axi_awvalid = 0, i_axi_wvalid = 0, i_axi_bready = 0;
  logic i_axi_arvalid = 0, i_axi_rready = 0;
  logic [13:0] i_sample = 0;
  logic [7:0] i_axi_awaddr = 0, i_axi_araddr = 0;
  logic [31:0] i_axi_wdata = 0;
  logic [3:0] i_axi_wstrb = 4'hf;
  logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
  logic o_sample_tick, o_cal_active, o_lane_valid, o_ila_repeat, o_link_reinit;
  logic o_lmfc_align, o_scramble_en;
  logic [1:0] o_axi_bresp, o_axi_rresp, o_lane_is_k, resp;
  logic [31:0] o_axi_rdata, rdat, v, n_words;
  logic [15:0] o_lane_word, w1, last_w;
  logic [4:0] o_k_minus1;
  logic [2:0] o_swing_code, o_deemph_code;
  int mismatches = 0, n_compared = 0, cyc = 0, n_al = 0, n_ri = 0, c;
  integer seed = 32'hf8539cf3;
  always #4 i_core_clk = ~i_core_clk;
  acl_top #(.P_PWRUP_CYC(24'h14), .P_CAL_CYC(24'h0a)) i_dut (.*);
  acl_rx_model i_rx (.i_clk(i_core_clk), .i_srst(i_srst), .i_word(o_lane_word),
    .i_valid(o_lane_valid), .o_n_words(n_words), .o_last(last_w));
  ////////////////////////////////////////////////////////////
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cyc++;
    n_al += o_lmfc_align;
    n_ri += o_link_reinit;
    if (cyc == 6000) begin
      mismatches++;
      print_verdict;
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 0;
    dd = 0;
    i_axi_awaddr <= a;
    i_axi_wdata <= d;
    i_axi_awvalid <= 1;
    i_axi_wvalid <= 1;
    while (!(ad && dd)) begin
      @(posedge i_core_clk);
      if (o_axi_awready) begin
        ad = 1;
        i_axi_awvalid <= 0;
      end
      if (o_axi_wready) begin
        dd = 1;
        i_axi_wvalid <= 0;
      end
    end
    tk($random(seed) & 1);
    i_axi_bready <= 1;
    do @(posedge i_core_clk); while (!o_axi_bvalid);
    resp = o_axi_bresp;
    i_axi_bready <= 0;
  endtask
  task rd(input logic [7:0] a);
    i_axi_araddr <= a;
    i_axi_arvalid <= 1;
    do @(posedge i_core_clk); while (!o_axi_arready);
    i_axi_arvalid <= 0;
    tk($random(seed) & 1);
    i_axi_rready <= 1;
    do @(posedge i_core_clk); while (!o_axi_rvalid);
    rdat = o_axi_rdata;
    resp = o_axi_rresp;
    i_axi_rready <= 0;
  endtask
  task wait_cal(input logic lvl, output int n);
    n = 0;
    while (o_cal_active !== lvl) begin
      @(posedge i_core_clk);
      n++;
    end
  endtask
  task gap(output int n);
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (!o_sample_tick);
  endtask
  task sref(input int k);
    repeat (k) begin
      i_sysref <= 1;
      tk(2);
      i_sysref <= 0;
      tk(6);
    end
    tk(4);
  endtask
  function logic [15:0] exp_word(input logic [13:0] s, input logic ob);
    return {s[13] ^ ob, s[12:0], 2'b00};
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    tk(3);
    i_srst <= 0;
    rd(8'h00); chk("ctrl_rst", rdat, 32'h0);
    rd(8'h04); chk("link_rst", rdat, 32'h0001001f);
    rd(8'h08); chk("drv_rst", rdat, 32'h0);
    rd(8'h0c); chk("stat_rst", rdat, 32'h10);
    i_supply_ok <= 1;
    i_clk_ok <= 1;
    wait_cal(1, c); chk("pwrup", c >= PW && c <= PW + 4, 1);
    rd(8'h0c); chk("cal_busy", rdat[1:0], 2'b10);
    wait_cal(0, c);
    rd(8'h0c); chk("cal_done", rdat[1:0], 2'b01);
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      i_sample <= v[13:0];
      wr(8'h00, {26'h0, 1'b1, v[15], v[14], 3'b000});
      tk(4);
      chk("fmt", last_w, exp_word(v[13:0], v[14]));
      chk("scr", o_scramble_en, v[15]);
    end
    for (int t = 1; t < 9; t++) begin
      wr(8'h04, {16'h0003, 4'h0, t[3:0], 3'h0, 5'h03});
      tk(3);
      w1 = o_lane_word;
      tk(1);
      case (t)
        1: chk("d215", w1, 16'hb5b5);
        2: chk("k285", {o_lane_is_k, w1}, 18'h3bcbc);
        3: chk("ila", o_ila_repeat, 1);
        7: chk("ramp", 16'(o_lane_word - w1), 16'h0003);
        8: chk("no_idle", w1, exp_word(v[13:0], v[14]));
        default: chk("prbs", o_lane_word != w1, 1);
      endcase
    end
    chk("k_floor", o_k_minus1, 5'h08);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      if (i < 2) v = {32{i[0]}};
      wr(8'h08, {25'h0, v[6:4], 1'b0, v[2:0]});
      rd(8'h08); chk("drv", rdat, {25'h0, v[6:4], 1'b0, v[2:0]});
      chk("drv_out", {o_deemph_code, o_swing_code}, {v[6:4], v[2:0]});
    end
    wr(8'h10, 32'h1); chk("bad_wr", resp, 2'b10);
    rd(8'h10); chk("bad_rd", resp, 2'b10);
    chk("bad_rdata", rdat, 32'h0);
    wr(8'h0c, 32'h0);
    rd(8'h0c); chk("stat_ro", rdat, 32'h11);
    for (int d = 1; d < 5; d++) begin
      c = n_ri;
      wr(8'h00, {26'h0, 1'b1, 2'b00, 2'(d % 4), 1'b0});
      tk(4);
      chk("reinit", n_ri - c, 1);
      gap(c);
      gap(c);
      chk("tick_gap", c, 1 << (d % 4));
    end
    // Divide by two, then recalibrate through power-down
    wr(8'h00, 32'h22);
    wr(8'h00, 32'h23);
    tk(3);
    c = n_words;
    tk(20);
    rd(8'h0c); chk("pd_stat", rdat[2:0], 3'b100);
    chk("pd_quiet", n_words - c, 0);
    wr(8'h00, 32'h02);
    // Fixed wait of 1.5 runs in ticks instead of polling
    tk(30);
    rd(8'h0c); chk("recal", rdat[2:0], 3'b001);
    chk("resumed", n_words != c, 1);
    c = n_al;
    sref(2);
    chk("gate_off", n_al - c, 0);
    wr(8'h00, 32'h22);
    // One-shot, short burst, longer periodic run
    for (int k = 1; k < 8; k = 2 * k + 1) begin
      c = n_al;
      sref(k);
      chk("align", n_al - c, k);
    end
    print_verdict;
  end
endmodule // adc_calibration_and_link_format_tb
`default_nettype wire
